// *** logic/mbx_bit_extract.v ***
// mask and right justify a fetched 16 or 32 bit word
`timescale 1ns/1ps
`default_nettype none

module mbx_bit_extract (
  input  wire [31:0] ext_data,
  input  wire [31:0] ext_mask,
  input  wire        ext_wide,
  output wire [31:0] ext_result
);

  wire [31:0] eff_mask;
  wire [31:0] anded;
  reg  [4:0]  low_pos;
  integer     i;

  // narrow maps keep a four digit mask
  assign eff_mask = ext_wide ? ext_mask : {16'h0000, ext_mask[15:0]};

  // per bit masking
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_and
      assign anded[g] = ext_data[g] & eff_mask[g];
    end
  endgenerate

  // position of lowest set mask bit
  always @* begin
    low_pos = 5'h00;
    for (i = 31; i >= 0; i = i - 1) begin
      if (eff_mask[i]) begin
        low_pos = i[4:0];
      end
    end
  end

  // lowest mask bit lands at bit 0
  assign ext_result = anded >> low_pos;

endmodule
`default_nettype wire

// *** logic/mbx_ref_decoder.v ***
// prefixed five and six digit reference decoder
`timescale 1ns/1ps
`default_nettype none
`include "mbx_map.vh"

module mbx_ref_decoder (
  input  wire [19:0] ref_value,
  input  wire        ref_six,
  output reg  [1:0]  ref_type,
  output reg  [15:0] ref_addr,
  output reg         ref_bad
);

  reg [19:0] base;
  reg [19:0] digit;
  reg [19:0] num;
  reg [19:0] top;

  // ==========================================
  // split leading digit from register number
  always @* begin
    base  = ref_six ? `MBX_REF6_BASE : `MBX_REF5_BASE;
    top   = ref_six ? `MBX_REF6_MAX_NUM : `MBX_REF5_MAX_NUM;
    digit = ref_value / base;
    num   = ref_value - digit * base;
    ref_type = `MBX_TYPE_COIL;
    ref_bad  = 1'b0;
    // leading digit selects the type
    if (digit == {16'h0000, `MBX_DIGIT_COIL}) begin
      ref_type = `MBX_TYPE_COIL;
    end else if (digit == {16'h0000, `MBX_DIGIT_DISC}) begin
      ref_type = `MBX_TYPE_DISC;
    end else if (digit == {16'h0000, `MBX_DIGIT_INPUT}) begin
      ref_type = `MBX_TYPE_INPUT;
    end else if (digit == {16'h0000, `MBX_DIGIT_HOLD}) begin
      ref_type = `MBX_TYPE_HOLD;
    end else begin
      ref_bad = 1'b1;
    end
    if (num == 20'h00000 || num > top) begin
      ref_bad = 1'b1;
    end
    // number minus one is the address
    ref_addr = num[15:0] - 16'h0001;
  end

endmodule
`default_nettype wire

// *** logic/mbx_unit.v ***
// request checker, reference decoder port and shared fetch bit extractor
// Function
// - a valid packet with an error gets an exception reply, not data
// - exception reply: unit address, function code with top bit set, code
// - unknown or forbidden function code answers exception code 1
// - any address in the requested range missing answers code 2
// - unacceptable data field value answers code 3
// - four types each own 0..65535; function code picks the type
// - leading digit 0 coil, 1 discrete, 3 input, 4 holding
// - address is reference minus type offset minus one
// - six digit references accepted with ranges up to 65535
// - 32-bit values travel in two consecutive 16-bit registers
// - high word sits in the lower numbered register by default
// - per map swap option reverses the two words
// - bit 0 is the least significant bit of a register
// - every mapped read ANDs data with mask; one bit gives 0 or 1
// - multi bit mask result shifted right to lowest mask bit
// - consecutive maps on one source register share a single fetch unless a wide map follows a narrow fetch
// - 16-bit mask four hex digits; bit n mask is one shifted by n
// - upper byte mask FF00, lower byte 00FF, right justified
// - 32 packed bits use eight digit masks for bits 16..31
`timescale 1ns/1ps
`default_nettype none
`include "mbx_map.vh"

module mbx_unit (
  input  wire        mclk,
  input  wire        rst,
  // request check side
  input  wire        req_valid,
  input  wire [7:0]  req_unit,
  input  wire [7:0]  req_func,
  input  wire [15:0] req_start,
  input  wire [15:0] req_qty,
  input  wire [15:0] req_value,
  input  wire [7:0]  func_allow,
  input  wire [16:0] coil_count,
  input  wire [16:0] disc_count,
  input  wire [16:0] input_count,
  input  wire [16:0] hold_count,
  output reg         rsp_valid,
  output reg         rsp_exc,
  output reg  [7:0]  rsp_unit,
  output reg  [7:0]  rsp_func,
  output reg  [7:0]  rsp_code,
  output reg  [1:0]  rsp_type,
  output reg  [15:0] rsp_addr,
  // reference decoder side
  input  wire        ref_valid,
  input  wire [19:0] ref_value,
  input  wire        ref_six,
  output reg         ref_done,
  output reg  [1:0]  ref_type,
  output reg  [15:0] ref_addr,
  output reg         ref_bad,
  // bit select helper
  input  wire [4:0]  bit_index,
  output wire [31:0] bit_mask,
  // map read side
  input  wire        map_valid,
  input  wire [1:0]  map_type,
  input  wire [15:0] map_addr,
  input  wire        map_wide,
  input  wire        map_swap,
  input  wire [31:0] map_mask,
  input  wire        map_flush,
  output wire        map_ready,
  output reg         map_done,
  output reg  [31:0] map_result,
  output reg  [31:0] map_word,
  // fetch side toward the register source
  output reg         fetch_req,
  output reg  [1:0]  fetch_type,
  output reg  [15:0] fetch_addr,
  output reg         fetch_wide,
  input  wire        fetch_ack,
  input  wire [15:0] fetch_first,
  input  wire [15:0] fetch_second
);

  // ==========================================
  // request checking
  reg        known;
  reg [1:0]  rtype;
  reg        fslot;
  reg [2:0]  fidx;
  reg [15:0] qmax;
  reg        single;
  reg [16:0] limit;
  reg [16:0] last;
  reg [7:0]  code;

  // classify function, type, quantity bound
  always @* begin
    known  = 1'b1;
    rtype  = `MBX_TYPE_HOLD;
    fidx   = 3'h0;
    qmax   = `MBX_MAX_RD_REGS;
    single = 1'b0;
    case (req_func)
      `MBX_FC_RD_COIL: begin
        rtype = `MBX_TYPE_COIL;
        fidx = 3'h0;
        qmax = `MBX_MAX_RD_BITS;
      end
      `MBX_FC_RD_DISC: begin
        rtype = `MBX_TYPE_DISC;
        fidx = 3'h1;
        qmax = `MBX_MAX_RD_BITS;
      end
      `MBX_FC_RD_HOLD: begin
        rtype = `MBX_TYPE_HOLD;
        fidx = 3'h2;
      end
      `MBX_FC_RD_INPUT: begin
        rtype = `MBX_TYPE_INPUT;
        fidx = 3'h3;
      end
      `MBX_FC_WR_COIL: begin
        rtype = `MBX_TYPE_COIL;
        fidx = 3'h4;
        single = 1'b1;
      end
      `MBX_FC_WR_HOLD: begin
        rtype = `MBX_TYPE_HOLD;
        fidx = 3'h5;
        single = 1'b1;
      end
      `MBX_FC_WR_COILS: begin
        rtype = `MBX_TYPE_COIL;
        fidx = 3'h6;
        qmax = `MBX_MAX_WR_BITS;
      end
      `MBX_FC_WR_HOLDS: begin
        rtype = `MBX_TYPE_HOLD;
        fidx = 3'h7;
        qmax = `MBX_MAX_WR_REGS;
      end
      default: begin
        known = 1'b0;
      end
    endcase
    fslot = known & func_allow[fidx];
  end

  // pick the existing count of the addressed type
  always @* begin
    if (rtype == `MBX_TYPE_COIL) begin
      limit = coil_count;
    end else if (rtype == `MBX_TYPE_DISC) begin
      limit = disc_count;
    end else if (rtype == `MBX_TYPE_INPUT) begin
      limit = input_count;
    end else begin
      limit = hold_count;
    end
  end

  // exception code, function first, then value, then address
  always @* begin
    last = {1'b0, req_start} + (single ? 17'h00000 : ({1'b0, req_qty} - 17'h00001));
    code = 8'h00;
    if (!fslot) begin
      code = `MBX_EXC_FUNC;
    end else if (!single && (req_qty == 16'h0000 || req_qty > qmax)) begin
      code = `MBX_EXC_VALUE;
    end else if (req_func == `MBX_FC_WR_COIL && req_value != `MBX_COIL_ON &&
                 req_value != `MBX_COIL_OFF) begin
      code = `MBX_EXC_VALUE;
    end else if (last >= limit) begin
      code = `MBX_EXC_ADDR;
    end
  end

  // registered reply, one cycle after the request
  always @(posedge mclk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_exc   <= 1'b0;
      rsp_unit  <= 8'h00;
      rsp_func  <= 8'h00;
      rsp_code  <= 8'h00;
      rsp_type  <= 2'h0;
      rsp_addr  <= 16'h0000;
    end else begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        rsp_exc  <= (code != 8'h00);
        rsp_unit <= req_unit;
        rsp_func <= (code != 8'h00) ? (req_func | `MBX_FC_EXC_FLAG) : req_func;
        rsp_code <= code;
        rsp_type <= rtype;
        rsp_addr <= req_start;
      end
    end
  end

  // ==========================================
  // reference decoding
  wire [1:0]  dec_type;
  wire [15:0] dec_addr;
  wire        dec_bad;

  mbx_ref_decoder u_ref (
    .ref_value (ref_value),
    .ref_six   (ref_six),
    .ref_type  (dec_type),
    .ref_addr  (dec_addr),
    .ref_bad   (dec_bad)
  );

  // hold decoded reference
  always @(posedge mclk) begin
    if (rst) begin
      ref_done <= 1'b0;
      ref_type <= 2'h0;
      ref_addr <= 16'h0000;
      ref_bad  <= 1'b0;
    end else begin
      ref_done <= ref_valid;
      if (ref_valid) begin
        ref_type <= dec_type;
        ref_addr <= dec_addr;
        ref_bad  <= dec_bad;
      end
    end
  end

  // single bit mask from bit number, bit 0 rightmost
  assign bit_mask = {31'h00000000, 1'b1} << bit_index;

  // ==========================================
  // map reads with shared fetch
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_FETCH = 3'b010;
  localparam [2:0] ST_DONE  = 3'b100;

  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  reg        hit_ok_reg;
  reg [1:0]  hit_type_reg;
  reg [15:0] hit_addr_reg;
  reg        hit_wide_reg;
  reg [15:0] first_reg;
  reg [15:0] second_reg;
  reg        swap_reg;
  reg        wide_reg;
  reg [31:0] mask_reg;
  wire       hit;
  wire [31:0] word;
  wire [31:0] ext_out;

  assign map_ready = (state_reg == ST_IDLE);
  assign hit = hit_ok_reg && hit_type_reg == map_type && hit_addr_reg == map_addr &&
               (hit_wide_reg || !map_wide);

  // pair assembly: first register high unless swapped
  assign word = !wide_reg ? {16'h0000, first_reg} :
                swap_reg ? {second_reg, first_reg} :
                {first_reg, second_reg};

  mbx_bit_extract u_ext (
    .ext_data   (word),
    .ext_mask   (mask_reg),
    .ext_wide   (wide_reg),
    .ext_result (ext_out)
  );

  // next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (map_valid) begin
          state_next = hit ? ST_DONE : ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (fetch_ack) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // map datapath and fetch control
  always @(posedge mclk) begin
    if (rst) begin
      state_reg    <= ST_IDLE;
      hit_ok_reg   <= 1'b0;
      hit_type_reg <= 2'h0;
      hit_addr_reg <= 16'h0000;
      hit_wide_reg <= 1'b0;
      first_reg    <= 16'h0000;
      second_reg   <= 16'h0000;
      swap_reg     <= 1'b0;
      wide_reg     <= 1'b0;
      mask_reg     <= 32'h00000000;
      fetch_req    <= 1'b0;
      fetch_type   <= 2'h0;
      fetch_addr   <= 16'h0000;
      fetch_wide   <= 1'b0;
      map_done     <= 1'b0;
      map_result   <= 32'h00000000;
      map_word     <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      map_done  <= 1'b0;
      if (state_reg == ST_IDLE && map_valid) begin
        swap_reg <= map_swap;
        wide_reg <= map_wide;
        mask_reg <= map_mask;
        if (!hit) begin
          fetch_req  <= 1'b1;
          fetch_type <= map_type;
          fetch_addr <= map_addr;
          fetch_wide <= map_wide;
          hit_ok_reg <= 1'b0;
        end
      end else if (state_reg == ST_FETCH && fetch_ack) begin
        fetch_req    <= 1'b0;
        first_reg    <= fetch_first;
        second_reg   <= fetch_second;
        hit_ok_reg   <= 1'b1;
        hit_type_reg <= fetch_type;
        hit_addr_reg <= fetch_addr;
        hit_wide_reg <= fetch_wide;
      end else if (state_reg == ST_DONE) begin
        map_done   <= 1'b1;
        map_result <= ext_out;
        map_word   <= word;
        if (map_flush) begin
          hit_ok_reg <= 1'b0;
        end
      end else if (map_flush) begin
        hit_ok_reg <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// *** shared/mbx_map.vh ***
// constants for the register access endpoint: codes, reference bases and masks
`ifndef MBX_MAP_VH
`define MBX_MAP_VH

// ==========================================
// register types (one address space each)
`define MBX_TYPE_COIL      2'h0
`define MBX_TYPE_DISC      2'h1
`define MBX_TYPE_INPUT     2'h2
`define MBX_TYPE_HOLD      2'h3

// ==========================================
// function codes
`define MBX_FC_RD_COIL     8'h01
`define MBX_FC_RD_DISC     8'h02
`define MBX_FC_RD_HOLD     8'h03
`define MBX_FC_RD_INPUT    8'h04
`define MBX_FC_WR_COIL     8'h05
`define MBX_FC_WR_HOLD     8'h06
`define MBX_FC_WR_COILS    8'h0F
`define MBX_FC_WR_HOLDS    8'h10
`define MBX_FC_EXC_FLAG    8'h80

// ==========================================
// exception codes
`define MBX_EXC_FUNC       8'h01
`define MBX_EXC_ADDR       8'h02
`define MBX_EXC_VALUE      8'h03

// ==========================================
// quantity limits and single coil values
`define MBX_MAX_RD_BITS    16'h07D0
`define MBX_MAX_RD_REGS    16'h007D
`define MBX_MAX_WR_BITS    16'h07B0
`define MBX_MAX_WR_REGS    16'h007B
`define MBX_COIL_ON        16'hFF00
`define MBX_COIL_OFF       16'h0000

// ==========================================
// prefixed reference decoding
`define MBX_REF5_BASE      20'h02710
`define MBX_REF6_BASE      20'h186A0
`define MBX_REF5_MAX_NUM   20'h0270F
`define MBX_REF6_MAX_NUM   20'h0FFFF
`define MBX_DIGIT_COIL     4'h0
`define MBX_DIGIT_DISC     4'h1
`define MBX_DIGIT_INPUT    4'h3
`define MBX_DIGIT_HOLD     4'h4

// ==========================================
// masks
`define MBX_MASK_BIT0      16'h0001
`define MBX_MASK_BIT15     16'h8000
`define MBX_MASK_HI_BYTE   16'hFF00
`define MBX_MASK_LO_BYTE   16'h00FF
`define MBX_MASK_BIT16     32'h00010000
`define MBX_MASK_BIT31     32'h80000000

`endif

// *** verif/mbx_src_model.sv ***
// register source model answering fetches after a random stall
`timescale 1ns/1ps
`default_nettype none
module mbx_src_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        fetch_req,
  input  wire logic [1:0]  fetch_type,
  input  wire logic [15:0] fetch_addr,
  output logic             fetch_ack,
  output logic [15:0]      fetch_first,
  output logic [15:0]      fetch_second
);
  logic [1:0] stall_reg;
  // whole registers on ack, toggling junk otherwise
  always @(posedge mclk) begin
    fetch_ack <= 1'b0;
    fetch_first <= ~fetch_first;
    fetch_second <= ~fetch_second;
    if (rst) begin
      stall_reg <= 2'h0;
      fetch_first <= 16'h0F0F;
      fetch_second <= 16'h3C3C;
    end else if (fetch_req && !fetch_ack) begin
      if (stall_reg == 2'h0) begin
        fetch_ack <= 1'b1;
        fetch_first <= fetch_addr ^ {fetch_type, 14'h1A3C};
        fetch_second <= ~fetch_addr ^ {fetch_type, 14'h0000};
        stall_reg <= 2'($urandom);
      end else begin
        stall_reg <= stall_reg - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/mbx_unit_properties.sv ***
// checker of port timing for request, reference, mask and fetch paths
`timescale 1ns/1ps
`default_nettype none
module mbx_unit_chk (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire logic [7:0]  req_unit,
  input wire logic [7:0]  req_func,
  input wire logic        rsp_valid,
  input wire logic        rsp_exc,
  input wire logic [7:0]  rsp_unit,
  input wire logic [7:0]  rsp_func,
  input wire logic [7:0]  rsp_code,
  input wire logic        ref_valid,
  input wire logic [19:0] ref_value,
  input wire logic        ref_six,
  input wire logic        ref_done,
  input wire logic [1:0]  ref_type,
  input wire logic [15:0] ref_addr,
  input wire logic        ref_bad,
  input wire logic [4:0]  bit_index,
  input wire logic [31:0] bit_mask,
  input wire logic        fetch_req,
  input wire logic        fetch_ack,
  input wire logic [15:0] fetch_addr,
  input wire logic        map_done
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================
  // named steps
  sequence s_ack;
    fetch_req && fetch_ack;
  endsequence
  sequence s_first_hold;
    ref_valid && !ref_six && ref_value == 20'h09C41;
  endsequence
  // ==========================================
  // properties
  AST_RSP_ONE: assert property (req_valid |=> rsp_valid)
    else $error("reply strobe missing");
  AST_EXC_FUNC: assert property (rsp_valid && rsp_exc |-> rsp_func == ($past(req_func) | 8'h80))
    else $error("exception function code wrong");
  AST_EXC_UNIT: assert property (rsp_valid |-> rsp_unit == $past(req_unit))
    else $error("reply unit wrong");
  AST_BAD_FUNC: assert property (req_valid && !(req_func inside {8'h01, 8'h02, 8'h03, 8'h04,
    8'h05, 8'h06, 8'h0F, 8'h10}) |=> rsp_exc && rsp_code == 8'h01)
    else $error("unknown function not refused");
  AST_REF_DONE: assert property (ref_valid |=> ref_done)
    else $error("decode strobe missing");
  AST_REF_HOLD: assert property (s_first_hold |=> ref_type == 2'h3 && ref_addr == 16'h0000 && !ref_bad)
    else $error("first holding reference wrong");
  AST_MASK: assert property (bit_mask == (32'h00000001 << bit_index))
    else $error("bit mask wrong");
  AST_FETCH: assert property (fetch_req && !fetch_ack |=> fetch_req && $stable(fetch_addr))
    else $error("fetch dropped early");
  AST_DONE: assert property (s_ack |-> ##2 map_done)
    else $error("map not done after fetch");
endmodule
bind mbx_unit mbx_unit_chk chk (.mclk(mclk), .rst(rst), .req_valid(req_valid),
  .req_unit(req_unit), .req_func(req_func), .rsp_valid(rsp_valid), .rsp_exc(rsp_exc),
  .rsp_unit(rsp_unit), .rsp_func(rsp_func), .rsp_code(rsp_code), .ref_valid(ref_valid),
  .ref_value(ref_value), .ref_six(ref_six), .ref_done(ref_done), .ref_type(ref_type),
  .ref_addr(ref_addr), .ref_bad(ref_bad), .bit_index(bit_index), .bit_mask(bit_mask),
  .fetch_req(fetch_req), .fetch_ack(fetch_ack), .fetch_addr(fetch_addr), .map_done(map_done));
`default_nettype wire

// *** verif/mbx_unit_tb.sv ***
// self-checking bench for request checks, decoding and extraction
`timescale 1ns/1ps
`default_nettype none
module mbx_unit_tb;
  logic        mclk, rst, req_valid, ref_valid, ref_six, map_valid, map_wide, map_swap, map_flush;
  logic [7:0]  req_unit, req_func, func_allow;
  logic [15:0] req_start, req_qty, req_value, map_addr;
  logic [16:0] coil_count, disc_count, input_count, hold_count;
  logic [19:0] ref_value;
  logic [4:0]  bit_index;
  logic [1:0]  map_type;
  logic [31:0] map_mask;
  wire         rsp_valid, rsp_exc, ref_done, ref_bad, map_ready, map_done, fetch_req, fetch_wide;
  wire         fetch_ack;
  wire [7:0]   rsp_unit, rsp_func, rsp_code;
  wire [1:0]   rsp_type, ref_type, fetch_type;
  wire [15:0]  rsp_addr, ref_addr, fetch_addr, fetch_first, fetch_second;
  wire [31:0]  bit_mask, map_result, map_word;
  integer      error_cnt = 0, n_checks = 0, cyc = 0, n_fetch = 0, i, j, k;

  mbx_unit dut (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req_unit(req_unit),
    .req_func(req_func), .req_start(req_start), .req_qty(req_qty), .req_value(req_value),
    .func_allow(func_allow), .coil_count(coil_count), .disc_count(disc_count),
    .input_count(input_count), .hold_count(hold_count), .rsp_valid(rsp_valid),
    .rsp_exc(rsp_exc), .rsp_unit(rsp_unit), .rsp_func(rsp_func), .rsp_code(rsp_code),
    .rsp_type(rsp_type), .rsp_addr(rsp_addr), .ref_valid(ref_valid), .ref_value(ref_value),
    .ref_six(ref_six), .ref_done(ref_done), .ref_type(ref_type), .ref_addr(ref_addr),
    .ref_bad(ref_bad), .bit_index(bit_index), .bit_mask(bit_mask), .map_valid(map_valid),
    .map_type(map_type), .map_addr(map_addr), .map_wide(map_wide), .map_swap(map_swap),
    .map_mask(map_mask), .map_flush(map_flush), .map_ready(map_ready), .map_done(map_done),
    .map_result(map_result), .map_word(map_word), .fetch_req(fetch_req),
    .fetch_type(fetch_type), .fetch_addr(fetch_addr), .fetch_wide(fetch_wide),
    .fetch_ack(fetch_ack), .fetch_first(fetch_first), .fetch_second(fetch_second));
  mbx_src_model src (.mclk(mclk), .rst(rst), .fetch_req(fetch_req), .fetch_type(fetch_type),
    .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_first(fetch_first),
    .fetch_second(fetch_second));

  // clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // cycle limit and fetch count
  always @(posedge mclk) begin
    cyc++;
    if (fetch_req && fetch_ack) n_fetch++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop;
    end
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function [7:0] exp_code(input [7:0] f, input [15:0] s, q, v);
    logic [16:0] c, l;
    integer n;
    n = (f >= 1 && f <= 6) ? f - 1 : (f == 15) ? 6 : (f == 16) ? 7 : 8;
    c = (f == 2) ? disc_count : (f == 4) ? input_count :
        (f == 3 || f == 6 || f == 16) ? hold_count : coil_count;
    l = (f <= 2) ? 17'h007D0 : (f <= 4) ? 17'h0007D : (f == 15) ? 17'h007B0 : 17'h0007B;
    if (n == 8) return 8'h01;
    if (!func_allow[n]) return 8'h01;
    if (f == 5) return (v != 16'h0000 && v != 16'hFF00) ? 8'h03 : (s >= c) ? 8'h02 : 8'h00;
    if (f == 6) return (s >= c) ? 8'h02 : 8'h00;
    if (q == 0 || q > l) return 8'h03;
    return ({1'b0, s} + q - 1 >= c) ? 8'h02 : 8'h00;
  endfunction
  function [18:0] exp_ref(input [19:0] r, input six);
    logic [19:0] b, d, n;
    b = six ? 20'h186A0 : 20'h02710;
    d = r / b;
    n = r % b;
    exp_ref[18] = !(d == 0 || d == 1 || d == 3 || d == 4) || n == 0 ||
                  n > (six ? 20'h0FFFF : 20'h0270F);
    exp_ref[17:16] = (d == 4) ? 2'h3 : (d == 3) ? 2'h2 : (d == 1) ? 2'h1 : 2'h0;
    exp_ref[15:0] = n[15:0] - 16'h0001;
  endfunction
  function [63:0] exp_map(input [1:0] t, input [15:0] a, input w, s, input [31:0] m);
    logic [15:0] f, g;
    logic [31:0] wd, mk, x;
    f = a ^ {t, 14'h1A3C};
    g = ~a ^ {t, 14'h0000};
    wd = w ? (s ? {g, f} : {f, g}) : {16'h0000, f};
    mk = w ? m : {16'h0000, m[15:0]};
    x = wd & mk;
    while (mk != 0 && !mk[0]) begin
      mk = mk >> 1;
      x = x >> 1;
    end
    return {wd, x};
  endfunction

  task do_req(input [7:0] f, input [15:0] s, q, v);
    logic [7:0] c;
    c = exp_code(f, s, q, v);
    req_valid = 1'b1;
    req_func = f;
    req_start = s;
    req_qty = q;
    req_value = v;
    req_unit = 8'($urandom);
    @(negedge mclk);
    chk(rsp_valid, 1, "strobe");
    chk(rsp_code, c, "code");
    chk(rsp_exc, c != 0, "exc");
    chk(rsp_func, (c != 0) ? (f | 8'h80) : f, "func");
    chk(rsp_unit, req_unit, "unit");
    if (c == 0) chk({rsp_type, rsp_addr}, {(f == 2) ? 2'h1 : (f == 4) ? 2'h2 :
      (f == 3 || f == 6 || f == 16) ? 2'h3 : 2'h0, s}, "type");
  endtask
  task do_ref(input [19:0] r, input six);
    logic [18:0] e;
    e = exp_ref(r, six);
    ref_valid = 1'b1;
    ref_value = r;
    ref_six = six;
    @(negedge mclk);
    chk(ref_done, 1, "decoded");
    chk(ref_bad, e[18], "bad");
    if (!e[18]) chk({ref_type, ref_addr}, e[17:0], "ref");
  endtask
  task do_map(input [1:0] t, input [15:0] a, input w, s, input [31:0] m);
    logic [63:0] e;
    e = exp_map(t, a, w, s, m);
    map_valid = 1'b1;
    map_type = t;
    map_addr = a;
    map_wide = w;
    map_swap = s;
    map_mask = m;
    for (k = 0; k < 40 && map_ready !== 1'b1; k++) @(negedge mclk);
    @(negedge mclk);
    map_valid = 1'b0;
    for (k = 0; k < 40 && map_done !== 1'b1; k++) @(negedge mclk);
    chk(map_done, 1, "done");
    chk(map_word, e[63:32], "word");
    chk(map_result, e[31:0], "result");
  endtask
  task flush;
    map_flush = 1'b1;
    @(negedge mclk);
    map_flush = 1'b0;
  endtask

  // main sequence
  initial begin
    {rst, req_valid, ref_valid, ref_six, map_valid, map_wide, map_swap, map_flush} = 8'h80;
    {req_unit, req_func, req_start, req_qty, req_value, map_addr, ref_value} = 0;
    {bit_index, map_type, map_mask} = 0;
    {coil_count, disc_count} = {17'h00100, 17'h00040};
    {input_count, hold_count} = {17'h10000, 17'h00200};
    func_allow = 8'hF7;
    void'($urandom(61807));
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk({map_ready, rsp_valid}, 2'h2, "reset");
    do_req(8'h03, 16'h01FF, 16'h0001, 16'h0000);
    do_req(8'h03, 16'h01FF, 16'h0002, 16'h0000);
    do_req(8'h03, 16'h0000, 16'h007E, 16'h0000);
    do_req(8'h04, 16'h0000, 16'h0001, 16'h0000);
    do_req(8'h05, 16'h0000, 16'h0000, 16'h1234);
    do_req(8'h10, 16'h01F0, 16'h0011, 16'h0000);
    do_req(8'h10, 16'h0000, 16'h007B, 16'h0000);
    do_req(8'h0F, 16'h0000, 16'h07B1, 16'h0000);
    for (i = 0; i < 60; i++)
      do_req(($urandom % 5 == 0) ? 8'($urandom) : 8'($urandom % 7 + 1) | 8'($urandom % 2 * 8),
        16'($urandom % 1024), 16'($urandom % 140), ($urandom % 2) ? 16'hFF00 : 16'($urandom % 3));
    req_valid = 1'b0;
    $display("test requests done");
    do_ref(20'h09C41, 0);
    do_ref(20'h0C34F, 0);
    do_ref(20'h07531, 0);
    do_ref(20'h02711, 0);
    do_ref(20'h00001, 0);
    do_ref(20'h00000, 0);
    do_ref(20'h04E21, 0);
    do_ref(20'h71A7F, 1);
    do_ref(20'h0FFFF, 1);
    do_ref(20'h493E0, 1);
    for (i = 0; i < 40; i++) do_ref(($urandom % 2) ? 20'($urandom % 500000) : 20'($urandom % 100000),
      i[0]);
    ref_valid = 1'b0;
    $display("test references done");
    for (i = 0; i < 32; i++) begin
      bit_index = i[4:0];
      @(negedge mclk);
      chk(bit_mask, 32'h00000001 << i, "mask");
    end
    $display("test masks done");
    flush;
    j = n_fetch;
    for (i = 0; i < 16; i++) do_map(2'h3, 16'h0010, 0, 0, 32'h00000001 << i);
    do_map(2'h3, 16'h0010, 0, 0, 32'h0000FF00);
    do_map(2'h3, 16'h0010, 0, 0, 32'h000000FF);
    do_map(2'h3, 16'h0010, 0, 0, 32'h00000FF0);
    chk(n_fetch - j, 1, "shared fetch");
    do_map(2'h3, 16'h0010, 1, 0, 32'hFFFFFFFF);
    do_map(2'h3, 16'h0010, 1, 1, 32'h0000FFFF);
    chk(n_fetch - j, 2, "wide refetch");
    flush;
    for (i = 16; i < 32; i++) do_map(2'h1, 16'h0020, 1, 0, 32'h00000001 << i);
    do_map(2'h1, 16'h0020, 1, 1, 32'hFFFFFFFF);
    for (i = 0; i < 40; i++) begin
      if ($urandom % 4 == 0) flush;
      do_map(2'($urandom), 16'($urandom % 4), 1'($urandom), 1'($urandom), $urandom);
    end
    $display("test maps done");
    report_and_stop;
  end
endmodule
`default_nettype wire
